// ===== ubpb_pkg.sv
// Shared constants and types for the USB bulk pipe bridge.
// Behaviour
// [R1] Forward each bulk OUT packet into FIFO
// [R2] Erroneous OUT packet rewinds FIFO write pointer
// [R3] Build bulk IN packets from stored frames
// [R4] Resend IN packet when handshake fails
// [R5] Advance FIFO read head only after ACK
// [R6] Multi-frame or single-frame packet encapsulation
// [R7] Handshake chosen from endpoint buffer state
// [R8] CRC and toggle errors handled, never forwarded
// [R9] SETUP packet clears endpoint stall
// [R10] Suspend, resume, reset handled; remote wakeup
// [R11] Exactly four endpoints: control, interrupt, bulk
// [R12] Unhandled control requests go to handler
// [R13] Buffers total 30 kB: 2 plus 28
// [R14] Link runs Hi-Speed only, 480 Mb/s
// [R15] Software zeroes reserved bits, avoids reserved addresses
// [R16] FIFO split 20 kB receive, 8 kB transmit
// [R17] Receive data handed over in 512-byte blocks
// [R18] Frames leave each pipe in entry order
package ubpb_pkg;
   // ==========================================================
   // Endpoint numbering
   // ==========================================================
   localparam int NUM_EP = 4; // R11
   localparam logic [1:0] EP_CONTROL = 2'h0;
   localparam logic [1:0] EP_INTR = 2'h1;
   localparam logic [1:0] EP_BULK_IN = 2'h2;
   localparam logic [1:0] EP_BULK_OUT = 2'h3;

   // ==========================================================
   // Buffer sizing and link rate
   // ==========================================================
   localparam int KB = 1024;
   localparam int TLB_BYTES = 2 * KB; // R13
   localparam int FIFO_BYTES = 28 * KB; // R13
   localparam int TOTAL_BYTES = TLB_BYTES + FIFO_BYTES;
   localparam int FIFO_RX_BYTES = 20 * KB; // R16
   localparam int FIFO_TX_BYTES = FIFO_BYTES - FIFO_RX_BYTES; // R16
   localparam int BLOCK_BYTES = 512; // R17
   localparam int LINK_MBPS = 480; // R14
   localparam int CLK_HZ = 20000000;
   localparam int DATA_W = 8;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [NUM_EP-1:0] STALL_RESET = 4'h0;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      HS_NONE = 3'b000,
      HS_ACK = 3'b001,
      HS_NAK = 3'b010,
      HS_STALL = 3'b011,
      HS_NYET = 3'b100
   } ubpb_hs_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01,
      RX_FINISH = 2'b10
   } ubpb_rx_e;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_FILL = 3'b001,
      TX_STAGED = 3'b010,
      TX_SEND = 3'b011,
      TX_WAIT = 3'b100,
      TX_ADVANCE = 3'b101
   } ubpb_tx_e;
endpackage

// ===== ubpb_pkt_ram.sv
// Retry buffer holding one staged bulk IN packet.
`timescale 1ns/100ps
module ubpb_pkt_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// ===== ubpb_bridge.sv
// Bulk OUT receiver, bulk IN transmitter and endpoint handshake logic.
`timescale 1ns/100ps
module ubpb_bridge #(
   parameter int PKT_BYTES = ubpb_pkg::BLOCK_BYTES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic multi_frame_mode,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic out_last,
   input wire logic out_crc_err,
   input wire logic out_toggle_err,
   output logic fct_wr_valid,
   output logic [7:0] fct_wr_data,
   output logic fct_wr_frame_end,
   output logic fct_wr_commit,
   output logic fct_wr_rewind,
   input wire logic fct_wr_ready,
   input wire logic fct_wr_space_low,
   input wire logic in_tok,
   output logic in_valid,
   output logic [7:0] in_data,
   output logic in_last,
   input wire logic in_ready,
   input wire logic in_ack,
   input wire logic in_timeout,
   input wire logic fct_rd_valid,
   input wire logic [7:0] fct_rd_data,
   input wire logic fct_rd_frame_end,
   output logic fct_rd_ready,
   output logic fct_rd_advance,
   output logic [$clog2(PKT_BYTES):0] fct_rd_adv_len,
   output logic fct_rd_rewind,
   input wire logic intr_tok,
   input wire logic intr_pending,
   output logic intr_send,
   output logic hs_valid,
   output logic [2:0] hs_code,
   input wire logic setup_valid,
   input wire logic [1:0] setup_ep,
   input wire logic setup_std_handled,
   output logic ctl_handoff,
   input wire logic [3:0] stall_req,
   output logic [3:0] ep_stalled,
   input wire logic bus_suspend,
   input wire logic bus_resume,
   input wire logic bus_reset,
   input wire logic wake_req,
   output logic suspended,
   output logic remote_wake
);
   localparam int AW = $clog2(PKT_BYTES);
   localparam int CW = AW + 1;

   // ==========================================================
   // Reset synchroniser
   // ==========================================================
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ==========================================================
   // Endpoint stall flags
   // ==========================================================
   logic [3:0] stall_q;

   // A stall request in the same cycle as SETUP wins, so a new stall is never lost.
   generate
      for (genvar e = 0; e < ubpb_pkg::NUM_EP; e++) begin : g_ep // R11
         always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
               stall_q[e] <= ubpb_pkg::STALL_RESET[e];
            end else if (stall_req[e]) begin
               stall_q[e] <= 1'b1;
            end else if (bus_reset || (setup_valid && setup_ep == 2'(e))) begin
               stall_q[e] <= 1'b0; // R9
            end
         end
      end
   endgenerate
   assign ep_stalled = stall_q;

   // ==========================================================
   // Bus state and remote wakeup
   // ==========================================================
   logic susp_q;
   logic wake_sent_q;
   logic wake_q;

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         susp_q <= 1'b0;
         wake_sent_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= susp_q && wake_req && !wake_sent_q && !wake_q; // R10
         if (bus_resume || bus_reset) begin
            susp_q <= 1'b0; // R10
            wake_sent_q <= 1'b0;
         end else begin
            if (bus_suspend) begin
               susp_q <= 1'b1; // R10
            end
            if (wake_q) begin
               wake_sent_q <= 1'b1;
            end
         end
      end
   end
   assign suspended = susp_q;
   assign remote_wake = wake_q;

   // ==========================================================
   // Control endpoint hand-off
   // ==========================================================
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         ctl_handoff <= 1'b0;
      end else begin
         ctl_handoff <= setup_valid && setup_ep == ubpb_pkg::EP_CONTROL
            && !setup_std_handled; // R12
      end
   end

   // ==========================================================
   // Bulk OUT receiver
   // ==========================================================
   ubpb_pkg::ubpb_rx_e rx_q;
   logic bad_q;
   logic crc_q;
   logic tog_q;
   logic ovf_q;
   logic rx_stall_q;
   logic byte_bad;

   // Toggle and CRC faults are flagged with the byte, so that byte is held back too.
   assign byte_bad = out_crc_err || out_toggle_err || !fct_wr_ready
      || stall_q[ubpb_pkg::EP_BULK_OUT] || bad_q;

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rx_q <= ubpb_pkg::RX_IDLE;
         bad_q <= 1'b0;
         crc_q <= 1'b0;
         tog_q <= 1'b0;
         ovf_q <= 1'b0;
         rx_stall_q <= 1'b0;
      end else if (bus_reset) begin
         rx_q <= ubpb_pkg::RX_IDLE;
         bad_q <= 1'b0;
      end else begin
         case (rx_q)
            ubpb_pkg::RX_IDLE, ubpb_pkg::RX_DATA: begin
               if (out_valid) begin
                  if (rx_q == ubpb_pkg::RX_IDLE) begin
                     crc_q <= out_crc_err;
                     tog_q <= out_toggle_err;
                     ovf_q <= !fct_wr_ready;
                     rx_stall_q <= stall_q[ubpb_pkg::EP_BULK_OUT];
                  end else begin
                     crc_q <= crc_q || out_crc_err; // R8
                     tog_q <= tog_q || out_toggle_err; // R8
                     ovf_q <= ovf_q || !fct_wr_ready;
                  end
                  bad_q <= byte_bad && !out_last; // R2
                  rx_q <= out_last ? ubpb_pkg::RX_FINISH : ubpb_pkg::RX_DATA;
               end
            end
            ubpb_pkg::RX_FINISH: begin
               rx_q <= ubpb_pkg::RX_IDLE;
            end
            default: begin
               rx_q <= ubpb_pkg::RX_IDLE;
            end
         endcase
      end
   end

   logic rx_start;
   logic rx_any_bad;
   assign rx_start = (rx_q == ubpb_pkg::RX_IDLE) && out_valid;
   assign rx_any_bad = crc_q || tog_q || ovf_q || rx_stall_q;

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         fct_wr_valid <= 1'b0;
         fct_wr_data <= 8'h00;
         fct_wr_frame_end <= 1'b0;
         fct_wr_commit <= 1'b0;
         fct_wr_rewind <= 1'b0;
      end else begin
         fct_wr_valid <= out_valid && !bus_reset && !(rx_start ? (out_crc_err
            || out_toggle_err || !fct_wr_ready || stall_q[ubpb_pkg::EP_BULK_OUT])
            : byte_bad); // R1
         fct_wr_data <= out_data; // R1
         // In single-frame mode each packet is one frame; in multi-frame mode the
         // FIFO controller finds the frame borders inside the packet itself.
         fct_wr_frame_end <= out_last && !multi_frame_mode; // R6
         fct_wr_commit <= (rx_q == ubpb_pkg::RX_FINISH) && !rx_any_bad; // R1 R18
         fct_wr_rewind <= (rx_q == ubpb_pkg::RX_FINISH) && rx_any_bad; // R2
      end
   end

   // ==========================================================
   // Bulk IN transmitter
   // ==========================================================
   ubpb_pkg::ubpb_tx_e tx_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] len_q;
   logic [CW-1:0] idx_q;
   logic boundary_q;
   logic pend_q;
   logic last_q;
   logic take;
   logic issue;
   logic stage_now;

   assign fct_rd_ready = (tx_q == ubpb_pkg::TX_FILL);
   assign take = fct_rd_ready && fct_rd_valid;
   assign stage_now = (take && ((!multi_frame_mode && fct_rd_frame_end) // R6
      || cnt_q == CW'(PKT_BYTES - 1))) // R17
      || (fct_rd_ready && !fct_rd_valid && boundary_q && cnt_q != '0); // R6
   assign issue = (tx_q == ubpb_pkg::TX_SEND) && !pend_q;

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         tx_q <= ubpb_pkg::TX_IDLE;
         cnt_q <= '0;
         len_q <= '0;
         idx_q <= '0;
         boundary_q <= 1'b0;
         pend_q <= 1'b0;
         last_q <= 1'b0;
      end else if (bus_reset) begin
         tx_q <= ubpb_pkg::TX_IDLE;
         pend_q <= 1'b0;
      end else begin
         case (tx_q)
            ubpb_pkg::TX_IDLE: begin
               cnt_q <= '0;
               boundary_q <= 1'b0;
               if (fct_rd_valid) begin
                  tx_q <= ubpb_pkg::TX_FILL;
               end
            end
            ubpb_pkg::TX_FILL: begin
               if (take) begin
                  cnt_q <= cnt_q + 1'b1; // R3 R18
                  boundary_q <= fct_rd_frame_end;
               end
               if (stage_now) begin
                  len_q <= take ? cnt_q + 1'b1 : cnt_q;
                  tx_q <= ubpb_pkg::TX_STAGED;
               end
            end
            ubpb_pkg::TX_STAGED: begin
               idx_q <= '0;
               if (in_tok && !stall_q[ubpb_pkg::EP_BULK_IN]) begin
                  tx_q <= ubpb_pkg::TX_SEND;
               end
            end
            ubpb_pkg::TX_SEND: begin
               if (issue) begin
                  pend_q <= 1'b1;
                  last_q <= (idx_q == len_q - 1'b1);
               end else if (in_ready) begin
                  pend_q <= 1'b0;
                  idx_q <= idx_q + 1'b1;
                  if (last_q) begin
                     tx_q <= ubpb_pkg::TX_WAIT;
                  end
               end
            end
            ubpb_pkg::TX_WAIT: begin
               if (in_ack) begin
                  tx_q <= ubpb_pkg::TX_ADVANCE; // R5
               end else if (in_timeout) begin
                  tx_q <= ubpb_pkg::TX_STAGED; // R4
               end
            end
            ubpb_pkg::TX_ADVANCE: begin
               tx_q <= ubpb_pkg::TX_IDLE;
            end
            default: begin
               tx_q <= ubpb_pkg::TX_IDLE;
            end
         endcase
      end
   end

   ubpb_pkt_ram #(
      .WIDTH(ubpb_pkg::DATA_W),
      .DEPTH(PKT_BYTES),
      .AW(AW)
   ) u_ram (
      .clk(clk),
      .rst_n(rst_sync_q),
      .wr_en(take),
      .wr_addr(cnt_q[AW-1:0]),
      .wr_data(fct_rd_data),
      .rd_en(issue),
      .rd_addr(idx_q[AW-1:0]),
      .rd_data(in_data)
   );

   // The packet stays in the retry buffer until ACK, so the FIFO head only moves then.
   assign in_valid = pend_q;
   assign in_last = pend_q && last_q;
   assign fct_rd_advance = (tx_q == ubpb_pkg::TX_ADVANCE); // R5
   assign fct_rd_adv_len = len_q;
   assign fct_rd_rewind = bus_reset;

   // ==========================================================
   // Handshake selection
   // ==========================================================
   ubpb_pkg::ubpb_hs_e hs_d;
   logic intr_d;

   always_comb begin
      hs_d = ubpb_pkg::HS_NONE;
      intr_d = 1'b0;
      if (rx_q == ubpb_pkg::RX_FINISH) begin
         if (rx_stall_q) begin
            hs_d = ubpb_pkg::HS_STALL; // R7
         end else if (crc_q) begin
            hs_d = ubpb_pkg::HS_NONE; // R8
         end else if (tog_q) begin
            hs_d = ubpb_pkg::HS_ACK; // R8
         end else if (ovf_q) begin
            hs_d = ubpb_pkg::HS_NAK; // R7
         end else begin
            hs_d = fct_wr_space_low ? ubpb_pkg::HS_NYET : ubpb_pkg::HS_ACK; // R7
         end
      end else if (in_tok) begin
         if (stall_q[ubpb_pkg::EP_BULK_IN]) begin
            hs_d = ubpb_pkg::HS_STALL; // R7
         end else if (tx_q != ubpb_pkg::TX_STAGED) begin
            hs_d = ubpb_pkg::HS_NAK; // R7
         end
      end else if (intr_tok) begin
         if (stall_q[ubpb_pkg::EP_INTR]) begin
            hs_d = ubpb_pkg::HS_STALL;
         end else if (!intr_pending) begin
            hs_d = ubpb_pkg::HS_NAK;
         end else begin
            intr_d = 1'b1; // R7
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         hs_valid <= 1'b0;
         hs_code <= 3'h0;
         intr_send <= 1'b0;
      end else begin
         hs_valid <= (hs_d != ubpb_pkg::HS_NONE);
         hs_code <= hs_d;
         intr_send <= intr_d;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   chk_bad_rewind: assert property (@(posedge clk) disable iff (!rst_sync_q) // R2
      (rx_q == ubpb_pkg::RX_FINISH && rx_any_bad && !bus_reset)
      |=> fct_wr_rewind && !fct_wr_commit)
      else $error("bad bulk OUT packet was not rewound");
   chk_good_commit: assert property (@(posedge clk) disable iff (!rst_sync_q) // R1
      (rx_q == ubpb_pkg::RX_FINISH && !rx_any_bad) |=> fct_wr_commit && !fct_wr_rewind)
      else $error("good bulk OUT packet was not committed");
   chk_crc_silent: assert property (@(posedge clk) disable iff (!rst_sync_q) // R8
      (rx_q == ubpb_pkg::RX_FINISH && crc_q && !rx_stall_q) |=> !hs_valid)
      else $error("handshake sent for corrupt packet");
   chk_ack_advance: assert property (@(posedge clk) disable iff (!rst_sync_q) // R5
      $rose(fct_rd_advance) |-> $past(in_ack) && $past(tx_q) == ubpb_pkg::TX_WAIT)
      else $error("read head advanced without ACK");
   chk_retry_stage: assert property (@(posedge clk) disable iff (!rst_sync_q) // R4
      (tx_q == ubpb_pkg::TX_WAIT && in_timeout && !in_ack && !bus_reset)
      |=> tx_q == ubpb_pkg::TX_STAGED ##1 idx_q == '0)
      else $error("timed out packet not restaged");
   chk_single_stage: assert property (@(posedge clk) disable iff (!rst_sync_q) // R6
      (take && fct_rd_frame_end && !multi_frame_mode && !bus_reset)
      |=> tx_q == ubpb_pkg::TX_STAGED && len_q == $past(cnt_q) + 1'b1)
      else $error("single frame did not close the packet");
   chk_empty_nak: assert property (@(posedge clk) disable iff (!rst_sync_q) // R7
      (in_tok && rx_q != ubpb_pkg::RX_FINISH && !stall_q[ubpb_pkg::EP_BULK_IN]
      && tx_q != ubpb_pkg::TX_STAGED) |=> hs_valid && hs_code == ubpb_pkg::HS_NAK)
      else $error("empty bulk IN endpoint did not NAK");
   chk_setup_unstall: assert property (@(posedge clk) disable iff (!rst_sync_q) // R9
      (setup_valid && stall_req == 4'h0) |=> !ep_stalled[$past(setup_ep)])
      else $error("SETUP did not clear stall");
   chk_wake_suspended: assert property (@(posedge clk) disable iff (!rst_sync_q) // R10
      remote_wake |-> $past(susp_q) && !$past(remote_wake))
      else $error("remote wakeup outside suspend");
   chk_fill_order: assert property (@(posedge clk) disable iff (!rst_sync_q) // R18
      (take && !stage_now && !bus_reset) |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("bulk IN bytes stored out of order");
endmodule

// ===== ubpb_far_model.sv
// Far-side model: FIFO receive stream and host pacing of bulk IN bytes.
`timescale 1ns/100ps
module ubpb_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   output logic fct_rd_valid,
   output logic [7:0] fct_rd_data,
   output logic fct_rd_frame_end,
   input wire logic fct_rd_ready,
   input wire logic in_valid,
   output logic in_ready
);
   logic [8:0] store_q[$];

   // ==========================================================
   // Stream and host pacing
   // ==========================================================
   // An empty stream shows a changing pattern so a stale byte is never mistaken for data.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         store_q.delete();
         {fct_rd_valid, fct_rd_frame_end, fct_rd_data, in_ready} <= '0;
      end else begin
         if (fct_rd_valid && fct_rd_ready) begin
            void'(store_q.pop_front());
         end
         if (store_q.size() > 0) begin
            fct_rd_valid <= 1'b1;
            {fct_rd_frame_end, fct_rd_data} <= store_q[0];
         end else begin
            {fct_rd_valid, fct_rd_frame_end} <= 2'h0;
            fct_rd_data <= ~fct_rd_data;
         end
         in_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
      end
   end
endmodule

// ===== testbench.sv
// Self-checking bench for the bulk pipe bridge.
`timescale 1ns/100ps
module testbench;
   localparam int PB = 16;
   logic clk, rst_n, multi_frame_mode, out_valid, out_last, out_crc_err, out_toggle_err;
   logic fct_wr_valid, fct_wr_frame_end, fct_wr_commit, fct_wr_rewind, fct_wr_ready;
   logic fct_wr_space_low, in_tok, in_valid, in_last, in_ready, in_ack, in_timeout;
   logic fct_rd_valid, fct_rd_frame_end, fct_rd_ready, fct_rd_advance, fct_rd_rewind;
   logic intr_tok, intr_pending, intr_send, hs_valid, setup_valid, setup_std_handled;
   logic ctl_handoff, bus_suspend, bus_resume, bus_reset, wake_req, suspended, remote_wake;
   logic slow;
   logic [7:0] out_data, fct_wr_data, in_data, fct_rd_data;
   logic [$clog2(PB):0] fct_rd_adv_len;
   logic [2:0] hs_code;
   logic [1:0] setup_ep;
   logic [3:0] stall_req, ep_stalled;
   int failures, n_checks, cyc, n_commit, n_rewind, n_intr, n_ctl, n_wake, c0;
   logic [8:0] wr_q[$], in_q[$];
   logic [7:0] exp_in[$];
   logic [31:0] hs_q[$], adv_q[$];
   bit [3:0] stall_m;

   ubpb_bridge #(.PKT_BYTES(PB)) ubpb_bridge_inst (.clk, .rst_n, .multi_frame_mode,
      .out_valid, .out_data, .out_last, .out_crc_err, .out_toggle_err, .fct_wr_valid,
      .fct_wr_data, .fct_wr_frame_end, .fct_wr_commit, .fct_wr_rewind, .fct_wr_ready,
      .fct_wr_space_low, .in_tok, .in_valid, .in_data, .in_last, .in_ready, .in_ack,
      .in_timeout, .fct_rd_valid, .fct_rd_data, .fct_rd_frame_end, .fct_rd_ready,
      .fct_rd_advance, .fct_rd_adv_len, .fct_rd_rewind, .intr_tok, .intr_pending,
      .intr_send, .hs_valid, .hs_code, .setup_valid, .setup_ep, .setup_std_handled,
      .ctl_handoff, .stall_req, .ep_stalled, .bus_suspend, .bus_resume, .bus_reset,
      .wake_req, .suspended, .remote_wake);

   ubpb_far_model ubpb_far_model_inst (.clk, .rst_n, .slow, .fct_rd_valid, .fct_rd_data,
      .fct_rd_frame_end, .fct_rd_ready, .in_valid, .in_ready);

   always #25 clk = ~clk;

   task automatic results();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   task automatic pulse(ref logic s, input int w = 0);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
      repeat (w) @(negedge clk);
   endtask

   // ==========================================================
   // Output monitor
   // ==========================================================
   always @(posedge clk) begin
      if (fct_wr_valid) wr_q.push_back({fct_wr_frame_end, fct_wr_data});
      if (fct_wr_commit) n_commit++;
      if (fct_wr_rewind) n_rewind++;
      if (hs_valid) hs_q.push_back(hs_code);
      if (in_valid && in_ready) in_q.push_back({in_last, in_data});
      if (fct_rd_advance) adv_q.push_back(fct_rd_adv_len);
      if (intr_send) n_intr++;
      if (ctl_handoff) n_ctl++;
      if (remote_wake) n_wake++;
      cyc++;
      if (cyc == 30000) begin
         failures++;
         $display("wrong value at %0t: run timed out", $time);
         results();
      end
   end

   task automatic out_pkt(input int n, input bit crc, tog, ovf, low);
      logic [8:0] ex[$];
      int c0, r0, eh;
      bit bad;
      logic [7:0] b;
      wr_q.delete();
      hs_q.delete();
      c0 = n_commit;
      r0 = n_rewind;
      fct_wr_space_low = low;
      bad = crc | tog | ovf | stall_m[3];
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         b = $urandom;
         {out_valid, out_data, out_last} = {1'b1, b, i == n - 1};
         out_crc_err = crc && out_last;
         out_toggle_err = tog && out_last;
         fct_wr_ready = !(ovf && i == 1);
         ex.push_back({out_last && !multi_frame_mode, b});
      end
      @(negedge clk);
      {out_valid, out_last, out_crc_err, out_toggle_err, fct_wr_ready} = 5'h01;
      repeat (3) @(negedge clk);
      fct_wr_space_low = 1'b0;
      eh = crc ? 0 : stall_m[3] ? ubpb_pkg::HS_STALL : ovf ? ubpb_pkg::HS_NAK :
         (low && !tog) ? ubpb_pkg::HS_NYET : ubpb_pkg::HS_ACK;
      check(hs_q.size(), eh != 0, "handshake count");
      if (eh != 0 && hs_q.size() > 0) check(hs_q[0], eh, "handshake code");
      check(n_commit - c0, !bad, "commit count");
      check(n_rewind - r0, bad, "rewind count");
      if (!bad) begin
         check(wr_q.size(), n, "written bytes");
         foreach (ex[i]) check(wr_q[i], ex[i], "written byte");
      end
   endtask

   task automatic load(input int n);
      logic [7:0] b;
      for (int i = 0; i < n; i++) begin
         b = $urandom;
         ubpb_far_model_inst.store_q.push_back({i == n - 1, b});
         exp_in.push_back(b);
      end
   endtask

   // Tokens repeat until one is taken, as staging runs at its own pace.
   task automatic fetch(input int len, input bit retry);
      int k;
      adv_q.delete();
      for (int rep = 0; rep <= retry; rep++) begin
         for (k = 0; k < 60; k++) begin
            hs_q.delete();
            in_q.delete();
            pulse(in_tok, 2);
            if (hs_q.size() == 0) break;
         end
         check(k < 60, 1, "token taken");
         for (k = 0; k < 400 && in_q.size() < len; k++) @(negedge clk);
         repeat (4) @(negedge clk);
         check(in_q.size(), len, "sent bytes");
         for (int i = 0; i < len; i++) check(in_q[i], {i == len - 1, exp_in[i]}, "sent byte");
         check(adv_q.size(), 0, "early advance");
         if (rep < retry) pulse(in_timeout);
      end
      pulse(in_ack, 2);
      check(adv_q.size(), 1, "advance count");
      check(adv_q[0], len, "advance length");
      repeat (len) void'(exp_in.pop_front());
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      {clk, rst_n, out_valid, out_last, out_crc_err, out_toggle_err, fct_wr_space_low} = 7'h00;
      {in_tok, in_ack, in_timeout, intr_tok, intr_pending, setup_valid} = 6'h00;
      {setup_std_handled, bus_suspend, bus_resume, bus_reset, wake_req, slow} = 6'h00;
      {out_data, setup_ep, stall_req, multi_frame_mode, fct_wr_ready} = 16'h0003;
      void'($urandom(80));
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      for (int m = 1; m >= 0; m--) begin
         multi_frame_mode = m;
         out_pkt(5, 0, 0, 0, 0);
         out_pkt(1, 0, 0, 0, 1);
         out_pkt(4, 1, 0, 0, 0);
         out_pkt(4, 0, 1, 0, 0);
         out_pkt(3, 0, 0, 1, 0);
      end
      $display("test bulk out done");
      hs_q.delete();
      pulse(in_tok, 2);
      check(hs_q.size(), 1, "idle token answer");
      check(hs_q[0], ubpb_pkg::HS_NAK, "idle token code");
      load(6);
      load(3);
      fetch(6, 1);
      fetch(3, 0);
      multi_frame_mode = 1'b1;
      slow = 1'b1;
      load(5);
      load(4);
      fetch(9, 1);
      load(20);
      fetch(PB, 0);
      fetch(20 - PB, 0);
      slow = 1'b0;
      $display("test bulk in done");
      c0 = n_ctl;
      setup_std_handled = 1'b1;
      for (int e = 0; e < ubpb_pkg::NUM_EP; e++) begin
         @(negedge clk) stall_req = 4'h1 << e;
         @(negedge clk) stall_req = 4'h0;
         @(negedge clk);
         check(ep_stalled, 4'h1 << e, "stall set");
         stall_m = 4'h1 << e;
         if (e == 3) out_pkt(3, 0, 0, 0, 0);
         hs_q.delete();
         if (e == 2) pulse(in_tok);
         repeat (2) @(negedge clk);
         if (e == 2) check(hs_q[0], ubpb_pkg::HS_STALL, "stalled token");
         setup_ep = e;
         pulse(setup_valid, 2);
         check(ep_stalled, 0, "stall cleared");
         stall_m = 4'h0;
      end
      check(n_ctl, c0, "handled setup kept");
      setup_std_handled = 1'b0;
      setup_ep = 2'h0;
      pulse(setup_valid, 3);
      check(n_ctl - c0, 1, "setup handed off");
      hs_q.delete();
      pulse(intr_tok, 2);
      check(hs_q[0], ubpb_pkg::HS_NAK, "interrupt idle");
      intr_pending = 1'b1;
      pulse(intr_tok, 2);
      intr_pending = 1'b0;
      check(n_intr, 1, "interrupt sent");
      $display("test control done");
      pulse(bus_suspend, 2);
      check(suspended, 1, "suspended");
      wake_req = 1'b1;
      repeat (6) @(negedge clk);
      wake_req = 1'b0;
      check(n_wake, 1, "one wakeup");
      pulse(bus_resume, 2);
      check(suspended, 0, "resumed");
      @(negedge clk) stall_req = 4'hF;
      @(negedge clk) stall_req = 4'h0;
      pulse(bus_reset, 2);
      check(ep_stalled, 0, "bus reset stalls");
      $display("test bus events done");
      results();
   end
endmodule
